// ---- sensor_trim_and_lock_config_bench.sv ----
module sensor_trim_and_lock_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ACC = 50;
    logic sys_clk, rst, ce, nv_wr, nv_done, ovd_pin, ref_ext_pin;
    logic [5:0]  nv_addr, cmd_addr, gain_temperature_slope;
    logic [25:0] nv_data;
    logic [31:0] cmd_data, rsp_data, rdat;
    logic [8:0]  gain_fine_trim, reference_fine_trim, offset_fine_trim;
    logic [26:0] trims;
    logic cmd_valid, cmd_ready, rsp_valid, ref_trim_select, ref_in_en, got;
    logic ref_out_en, ref_overdrive_ok, ref_hiz, output_drive_select;
    logic comm_unlocked, comm_disabled;
    stc_pkg::stc_cmd_t cmd_kind;
    int num_errors, n_tests, cycles;
    integer seed;
    assign trims = {offset_fine_trim, reference_fine_trim, gain_fine_trim};

    stc_trim_lock_cfg #(.ACC_CYCLES(ACC)) dut (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .nv_wr(nv_wr),
        .nv_addr(nv_addr), .nv_data(nv_data), .nv_done(nv_done),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .ovd_pin(ovd_pin), .ref_ext_pin(ref_ext_pin),
        .gain_fine_trim(gain_fine_trim),
        .reference_fine_trim(reference_fine_trim),
        .offset_fine_trim(offset_fine_trim),
        .gain_temperature_slope(gain_temperature_slope),
        .ref_trim_select(ref_trim_select), .ref_in_en(ref_in_en),
        .ref_out_en(ref_out_en), .ref_overdrive_ok(ref_overdrive_ok),
        .ref_hiz(ref_hiz), .output_drive_select(output_drive_select),
        .comm_unlocked(comm_unlocked), .comm_disabled(comm_disabled));

    stc_ctl_model ctl (
        .sys_clk(sys_clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .ovd_pin(ovd_pin));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic summarize();
        if (num_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            $display("CHECK FAILED %0t run too long", $time);
            summarize();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    function automatic logic [31:0] mode_word(input logic [1:0] dir,
        input logic drv, input logic dis, input logic [5:0] slope);
        return {22'h000000, slope, dis, drv, dir};
    endfunction : mode_word

    function automatic logic trim_sel(input logic [1:0] dir, input logic ext);
        return dir == 2'h2 || (dir == 2'h3 && !ext);
    endfunction : trim_sel

    task automatic do_reset(input int n);
        rst = 1'b1;
        nv_done = 1'b0;
        repeat (n) @(negedge sys_clk);
        chk(ref_overdrive_ok, 1'b1, "overdrive in reset");
        chk(cmd_ready, 1'b0, "ready before load");
        rst = 1'b0;
        @(negedge sys_clk);
    endtask : do_reset

    task automatic nv_load(input logic [5:0] a, input logic [25:0] d);
        nv_wr = 1'b1;
        nv_addr = a;
        nv_data = d;
        @(negedge sys_clk);
    endtask : nv_load

    // The write strobe stays up between loads and drops only here.
    task automatic nv_finish();
        nv_wr = 1'b0;
        nv_data = ~nv_data;
        nv_done = 1'b1;
        @(negedge sys_clk);
        nv_done = 1'b0;
        chk(cmd_ready, 1'b1, "ready after load");
    endtask : nv_finish

    task automatic wr(input logic [5:0] a, input logic [25:0] d);
        ctl.send(stc_pkg::CMD_WRITE, a, {6'h00, d}, 1'b0, got, rdat);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        ctl.send(stc_pkg::CMD_READ, a, 32'h00000000, 1'b0, got, rdat);
        chk(got, 1'b1, "read not answered");
        chk(rdat, e, "read data");
        chk(rsp_valid, 1'b0, "answer held too long");
        chk(rsp_data, e, "answer not kept");
    endtask : rd

    initial begin
        logic [8:0]  t;
        logic [1:0]  dir;
        logic [31:0] r;
        logic [25:0] lw;
        logic [5:0]  a;
        seed = 64349;
        {rst, ce, nv_wr, nv_done, ref_ext_pin} = 5'h18;
        nv_addr = 6'h00;
        nv_data = 26'h0000000;
        do_reset(20);
        r = $random(seed);
        t = ctl.legal_trim(r);
        nv_load(stc_pkg::ADDR_LOCK_CFG, 26'h2000000);
        nv_load(stc_pkg::ADDR_GAIN_FINE, {17'h00000, t});
        nv_finish();
        chk(gain_fine_trim, t, "loaded trim");
        ctl.send(stc_pkg::CMD_READ, stc_pkg::ADDR_GAIN_FINE, 32'h0, 1'b0, got,
                 rdat);
        chk(got, 1'b0, "read while locked");
        ctl.send(stc_pkg::CMD_ACCESS, stc_pkg::ADDR_ACCESS,
                 stc_pkg::CODE_USER, 1'b1, got, rdat);
        chk(comm_unlocked, 1'b0, "one code of two");
        wr(stc_pkg::ADDR_GAIN_FINE, 26'h0000000);
        chk(gain_fine_trim, t, "write while locked");
        ctl.unlock(1'b1);
        chk(comm_unlocked, 1'b1, "dual unlock");
        rd(6'h3E, 32'h00000000);
        ce = 1'b0;
        wr(stc_pkg::ADDR_GAIN_FINE, {17'h00000, ~t});
        ce = 1'b1;
        chk(gain_fine_trim, t, "write while frozen");
        for (int j = 0; j < 6; j++) begin
            a = stc_pkg::ADDR_GAIN_FINE + 6'(j % 3);
            r = $random(seed);
            t = (j < 3) ? ((j == 1) ? 9'h0DF : 9'h120) : ctl.legal_trim(r);
            wr(a, {17'h00000, t});
            chk(trims[(j % 3) * 9 +: 9], t, "trim out");
            rd(a, {23'h000000, t});
        end
        for (int m = 0; m < 8; m++) begin
            dir = 2'(m >> 1);
            r = $random(seed);
            ref_ext_pin = m[0];
            wr(stc_pkg::ADDR_MODE, 26'(mode_word(dir, r[6], 1'b0, r[5:0])));
            repeat (3) @(negedge sys_clk);
            chk(ref_in_en, dir != 2'h2, "input enable");
            chk(ref_out_en, dir[1], "output enable");
            chk(ref_overdrive_ok, dir == 2'h3, "overdrive");
            chk(output_drive_select, r[6], "drive");
            chk(gain_temperature_slope, r[5:0], "slope");
            chk(ref_trim_select, trim_sel(dir, m[0]), "ref source");
            rd(stc_pkg::ADDR_MODE,
               mode_word(dir, r[6], 1'b0, r[5:0]));
        end
        lw = {2'h3, r[23:0]};
        wr(stc_pkg::ADDR_LOCK_CFG, lw);
        ctl.send(stc_pkg::CMD_READ, stc_pkg::ADDR_LOCK_CFG, 32'h0, 1'b0, got,
                 rdat);
        chk(got, 1'b0, "read without event");
        ctl.ovd_pulse();
        chk(ref_hiz, 1'b1, "released on event");
        rd(stc_pkg::ADDR_LOCK_CFG,
           {6'h00, lw[25:24], 24'h000000});
        chk(ref_hiz, 1'b0, "driven after access");
        ctl.send(stc_pkg::CMD_READ, stc_pkg::ADDR_MODE, 32'h0, 1'b0, got, rdat);
        chk(got, 1'b0, "event used once");
        ctl.ovd_pulse();
        wr(stc_pkg::ADDR_MODE, 26'(mode_word(2'h3, 1'b0, 1'b1, 6'h00)));
        ctl.ovd_pulse();
        chk(ref_hiz, 1'b0, "disabled release");
        rd(stc_pkg::ADDR_MODE, mode_word(2'h3, 1'b0, 1'b1, 6'h00));
        do_reset(2);
        nv_load(stc_pkg::ADDR_LOCK_CFG, 26'h1000000);
        nv_finish();
        ctl.unlock(1'b0);
        chk(comm_unlocked, 1'b1, "unlock without event");
        chk(comm_disabled, 1'b0, "not disabled");
        do_reset(2);
        nv_finish();
        repeat (ACC - 3) @(negedge sys_clk);
        chk(comm_disabled, 1'b0, "disabled too early");
        @(negedge sys_clk);
        chk(comm_disabled, 1'b1, "timeout disable");
        chk(cmd_ready, 1'b0, "refused after timeout");
        summarize();
    end
endmodule : sensor_trim_and_lock_config_bench

// ---- stc_ctl_model.sv ----
module stc_ctl_model (
    input  wire logic         sys_clk,
    input  wire logic         cmd_ready,
    input  wire logic         rsp_valid,
    input  wire logic [31:0]  rsp_data,
    output logic              cmd_valid,
    output stc_pkg::stc_cmd_t cmd_kind,
    output logic [5:0]        cmd_addr,
    output logic [31:0]       cmd_data,
    output logic              ovd_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cmd_valid = 1'b0;
        cmd_kind  = stc_pkg::CMD_READ;
        cmd_addr  = 6'h2A;
        cmd_data  = 32'h5A5A5A5A;
        ovd_pin   = 1'b0;
    end

    // Maps a raw number onto a code clear of both signed extremes.
    function automatic logic [8:0] legal_trim(input logic [31:0] r);
        logic [8:0] v;
        v = 9'(r % 32'h000001C0);
        return (v < 9'h0E0) ? v : v + 9'h040;
    endfunction : legal_trim

    // Released lines are inverted so that stale values never look valid.
    task automatic idle();
        cmd_valid = 1'b0;
        cmd_addr  = ~cmd_addr;
        cmd_data  = ~cmd_data;
    endtask : idle

    // Called at a falling edge; with keep set it returns one falling edge
    // after the taking edge with valid still held, otherwise it releases
    // the lines and lets one more edge pass so valid never toggles twice.
    task automatic send(input stc_pkg::stc_cmd_t kind, input logic [5:0] addr,
                        input logic [31:0] data, input bit keep,
                        output logic got, output logic [31:0] rdata);
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd_kind  = kind;
        cmd_addr  = addr;
        cmd_data  = data;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        got   = rsp_valid;
        rdata = rsp_data;
        if (!keep) begin
            idle();
            @(negedge sys_clk);
        end
    endtask : send

    // Two codes are sent back to back when the two argument is set.
    task automatic unlock(input bit two);
        logic        g;
        logic [31:0] d;
        send(stc_pkg::CMD_ACCESS, stc_pkg::ADDR_ACCESS, stc_pkg::CODE_UNLOCK,
             two, g, d);
        if (two) begin
            send(stc_pkg::CMD_ACCESS, stc_pkg::ADDR_ACCESS, stc_pkg::CODE_USER,
                 1'b0, g, d);
        end
    endtask : unlock

    // The pulse is held long enough to pass the pin synchroniser.
    task automatic ovd_pulse();
        ovd_pin = 1'b1;
        repeat (4) @(negedge sys_clk);
        ovd_pin = 1'b0;
    endtask : ovd_pulse
endmodule : stc_ctl_model

// ---- stc_pkg.sv ----
// What this block does
// - With the per-access lock bit (bit 24 of the lock word) clear, reads and writes after unlock need no overvoltage event; with it set, each one needs a fresh event first.
// - The per-access lock bit leaves the unlock sequence untouched and only gates traffic after unlock.
// - With the dual-key bit (bit 25 of the lock word) clear, one unlock code opens the link; with it set, two codes must arrive back to back.
// - The dual-key bit acts only on the unlock step and never on reads or writes after unlock.
// - The reference pin may go high impedance on an overvoltage event during traffic only while the overvoltage-detect disable bit is 0, its default.
// - The fine gain trim is two's complement, zero meaning nominal gain.
// - Except in direction code 2, when the reference pin is driven from outside, its voltage is the reference and the internal reference trims are ignored.
// - The fine offset trim is two's complement and moves the zero-field output without touching the reference pin.
// - Reference direction codes 0 and 1 mean input only, 2 output only, 3 (default) driven output that may be overdriven.
// - Output drive select 0 (default) is full 15 mA drive and 1 is economy 7.5 mA drive.
// - The gain temperature slope is a 6-bit two's complement code pivoting at 25 degrees C.
// - In the default bidirectional mode the reference pin tolerates external overdrive, also while in reset.
// - An access code must arrive within the access timeout after power-up, otherwise all reads and writes are disabled.
package stc_pkg;
    localparam logic [5:0]  ADDR_LOCK_CFG   = 6'h0F;
    localparam logic [5:0]  ADDR_GAIN_FINE  = 6'h10;
    localparam logic [5:0]  ADDR_REF_FINE   = 6'h11;
    localparam logic [5:0]  ADDR_OFF_FINE   = 6'h12;
    localparam logic [5:0]  ADDR_MODE       = 6'h13;
    localparam logic [5:0]  ADDR_ACCESS     = 6'h26;
    localparam logic [31:0] CODE_USER       = 32'h2C413736;
    localparam logic [31:0] CODE_UNLOCK     = 32'hAFCF6C27;
    localparam int          LOCK_OVD_BIT    = 24;
    localparam int          LOCK_DUAL_BIT   = 25;
    localparam int          MODE_DIR_LSB    = 0;
    localparam int          MODE_DRIVE_BIT  = 2;
    localparam int          MODE_OVDDIS_BIT = 3;
    localparam int          MODE_SLOPE_LSB  = 4;
    localparam int          TRIM_W          = 9;
    localparam int          SLOPE_W         = 6;
    localparam int          DATA_W          = 26;
    localparam logic [1:0]  RST_REF_DIR     = 2'h3;
    localparam logic        RST_DRIVE       = 1'h0;
    localparam logic        RST_OVERVOLTAGE_DETECT_DISABLE     = 1'h0;
    localparam logic        RST_LOCK_BIT    = 1'h0;
    localparam logic [8:0]  RST_TRIM        = 9'h000;
    localparam logic [5:0]  RST_SLOPE       = 6'h00;
    localparam logic [1:0]  REF_DIR_OUT     = 2'h2;
    localparam logic [1:0]  REF_DIR_BIDIR   = 2'h3;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          ACC_TIMEOUT_US  = 1000;
    localparam int          ACC_TIMEOUT_CYC = ACC_TIMEOUT_US * 1000
                                              / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        CMD_ACCESS,
        CMD_WRITE,
        CMD_READ
    } stc_cmd_t;

    typedef enum logic [1:0] {
        UL_WAIT,
        UL_SECOND,
        UL_OPEN,
        UL_DISABLED
    } stc_ul_state_t;
endpackage : stc_pkg

// ---- stc_trim_lock_cfg.sv ----
module stc_trim_lock_cfg #(
    parameter int unsigned ACC_CYCLES = stc_pkg::ACC_TIMEOUT_CYC
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic         nv_wr,
    input  wire logic [5:0]   nv_addr,
    input  wire logic [25:0]  nv_data,
    input  wire logic         nv_done,
    input  wire logic         cmd_valid,
    output logic              cmd_ready,
    input  stc_pkg::stc_cmd_t cmd_kind,
    input  wire logic [5:0]   cmd_addr,
    input  wire logic [31:0]  cmd_data,
    output logic              rsp_valid,
    output logic [31:0]       rsp_data,
    input  wire logic         ovd_pin,
    input  wire logic         ref_ext_pin,
    output logic [8:0]        gain_fine_trim,
    output logic [8:0]        reference_fine_trim,
    output logic [8:0]        offset_fine_trim,
    output logic [5:0]        gain_temperature_slope,
    output logic              ref_trim_select,
    output logic              ref_in_en,
    output logic              ref_out_en,
    output logic              ref_overdrive_ok,
    output logic              ref_hiz,
    output logic              output_drive_select,
    output logic              comm_unlocked,
    output logic              comm_disabled
);
    logic        ovd_s1_r, ovd_s2_r, ovd_s3_r;
    logic        ext_s1_r, ext_s2_r;
    logic        loaded_r;
    logic        lock_ovd_r, lock_dual_r;
    logic [8:0]  gain_r, ref_r, off_r;
    logic [5:0]  slope_r;
    logic [1:0]  dir_r;
    logic        drive_r, overvoltage_detect_disable_r;
    logic        armed_r, hiz_r;
    logic        rsp_valid_r;
    logic [31:0] rsp_data_r;
    logic        ovd_rise, acc, key_ok, cmd_other, rw, go;
    logic        wr_en;
    logic [5:0]  wr_addr;
    logic [25:0] wr_data;
    logic [25:0] rd_word;
    logic        unlocked, disabled;

    // Pin inputs are synchronised; the second stage is looked at, and the overvoltage edge detect also uses the third.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ovd_s1_r <= 1'b0;
            ovd_s2_r <= 1'b0;
            ovd_s3_r <= 1'b0;
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
        end else if (ce) begin
            ovd_s1_r <= ovd_pin;
            ovd_s2_r <= ovd_s1_r;
            ovd_s3_r <= ovd_s2_r;
            ext_s1_r <= ref_ext_pin;
            ext_s2_r <= ext_s1_r;
        end
    end

    assign ovd_rise  = ovd_s2_r & ~ovd_s3_r;
    assign cmd_ready = loaded_r & ~disabled;
    assign acc       = cmd_valid & cmd_ready & ce;
    assign key_ok    = acc && cmd_kind == stc_pkg::CMD_ACCESS
                       && cmd_addr == stc_pkg::ADDR_ACCESS
                       && (cmd_data == stc_pkg::CODE_USER
                           || cmd_data == stc_pkg::CODE_UNLOCK);
    assign cmd_other = acc & ~key_ok;
    assign rw        = acc && unlocked && cmd_kind != stc_pkg::CMD_ACCESS;
    assign go        = rw & (~lock_ovd_r | armed_r);

    stc_unlock #(
        .ACC_CYCLES (ACC_CYCLES)
    ) u_unlock (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .ce        (ce),
        .key_ok    (key_ok),
        .cmd_other (cmd_other),
        .dual_key  (lock_dual_r),
        .unlocked  (unlocked),
        .disabled  (disabled)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            loaded_r <= 1'b0;
        end else if (ce && nv_done) begin
            loaded_r <= 1'b1;
        end
    end

    // Nonvolatile load owns the write port until it is done.
    always_comb begin
        if (!loaded_r) begin
            wr_en   = nv_wr;
            wr_addr = nv_addr;
            wr_data = nv_data;
        end else begin
            wr_en   = go && cmd_kind == stc_pkg::CMD_WRITE;
            wr_addr = cmd_addr;
            wr_data = cmd_data[25:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lock_ovd_r  <= stc_pkg::RST_LOCK_BIT;
            lock_dual_r <= stc_pkg::RST_LOCK_BIT;
            gain_r      <= stc_pkg::RST_TRIM;
            ref_r       <= stc_pkg::RST_TRIM;
            off_r       <= stc_pkg::RST_TRIM;
            dir_r       <= stc_pkg::RST_REF_DIR;
            drive_r     <= stc_pkg::RST_DRIVE;
            overvoltage_detect_disable_r   <= stc_pkg::RST_OVERVOLTAGE_DETECT_DISABLE;
            slope_r     <= stc_pkg::RST_SLOPE;
        end else if (ce && wr_en) begin
            if (wr_addr == stc_pkg::ADDR_LOCK_CFG) begin
                lock_ovd_r  <= wr_data[stc_pkg::LOCK_OVD_BIT];
                lock_dual_r <= wr_data[stc_pkg::LOCK_DUAL_BIT];
            end else if (wr_addr == stc_pkg::ADDR_GAIN_FINE) begin
                gain_r <= wr_data[8:0];
            end else if (wr_addr == stc_pkg::ADDR_REF_FINE) begin
                ref_r <= wr_data[8:0];
            end else if (wr_addr == stc_pkg::ADDR_OFF_FINE) begin
                off_r <= wr_data[8:0];
            end else if (wr_addr == stc_pkg::ADDR_MODE) begin
                dir_r     <= wr_data[stc_pkg::MODE_DIR_LSB +: 2];
                drive_r   <= wr_data[stc_pkg::MODE_DRIVE_BIT];
                overvoltage_detect_disable_r <= wr_data[stc_pkg::MODE_OVDDIS_BIT];
                slope_r   <= wr_data[stc_pkg::MODE_SLOPE_LSB +: 6];
            end
        end
    end

    // An event in the cycle that consumes the arming keeps it armed.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            armed_r <= 1'b0;
        end else if (ce) begin
            armed_r <= ovd_rise | (armed_r & ~go);
        end
    end

    // High impedance lasts from the event until the access it announced.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hiz_r <= 1'b0;
        end else if (ce) begin
            hiz_r <= ~overvoltage_detect_disable_r & ~disabled
                     & (ovd_rise | (hiz_r & ~go));
        end
    end

    always_comb begin
        rd_word = 26'h000_0000;
        if (cmd_addr == stc_pkg::ADDR_LOCK_CFG) begin
            rd_word[stc_pkg::LOCK_OVD_BIT]  = lock_ovd_r;
            rd_word[stc_pkg::LOCK_DUAL_BIT] = lock_dual_r;
        end else if (cmd_addr == stc_pkg::ADDR_GAIN_FINE) begin
            rd_word[8:0] = gain_r;
        end else if (cmd_addr == stc_pkg::ADDR_REF_FINE) begin
            rd_word[8:0] = ref_r;
        end else if (cmd_addr == stc_pkg::ADDR_OFF_FINE) begin
            rd_word[8:0] = off_r;
        end else if (cmd_addr == stc_pkg::ADDR_MODE) begin
            rd_word[stc_pkg::MODE_DIR_LSB +: 2]   = dir_r;
            rd_word[stc_pkg::MODE_DRIVE_BIT]      = drive_r;
            rd_word[stc_pkg::MODE_OVDDIS_BIT]     = overvoltage_detect_disable_r;
            rd_word[stc_pkg::MODE_SLOPE_LSB +: 6] = slope_r;
        end
    end

    // Answer bits 27:26 report no error; bits 31:28 read as zero.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rsp_valid_r <= 1'b0;
            rsp_data_r  <= 32'h0000_0000;
        end else if (ce) begin
            rsp_valid_r <= go && cmd_kind == stc_pkg::CMD_READ;
            if (go && cmd_kind == stc_pkg::CMD_READ) begin
                rsp_data_r <= {6'h00, rd_word};
            end
        end
    end

    assign rsp_valid              = rsp_valid_r;
    assign rsp_data               = rsp_data_r;
    // Trim codes leave as raw two's complement for the signed DACs.
    assign gain_fine_trim         = gain_r;
    assign reference_fine_trim    = ref_r;
    assign offset_fine_trim       = off_r;
    assign gain_temperature_slope = slope_r;
    assign ref_in_en              = (dir_r
                                     != stc_pkg::REF_DIR_OUT);
    assign ref_out_en             = dir_r[1];
    assign ref_overdrive_ok       = (dir_r
                                     == stc_pkg::REF_DIR_BIDIR);
    assign ref_trim_select        = (dir_r == stc_pkg::REF_DIR_OUT)
                                    || (dir_r == stc_pkg::REF_DIR_BIDIR
                                        && !ext_s2_r);
    assign ref_hiz                = hiz_r;
    assign output_drive_select    = drive_r;
    assign comm_unlocked          = unlocked;
    assign comm_disabled          = disabled;

    a_lock_needs_ovd: assert property (
        @(posedge sys_clk) disable iff (rst)
        (rw && lock_ovd_r && !armed_r && cmd_kind == stc_pkg::CMD_READ)
        |=> !rsp_valid)
        else $error("Read answered without an overvoltage event.");

    a_read_answers: assert property (
        @(posedge sys_clk) disable iff (rst)
        (rw && !lock_ovd_r && cmd_kind == stc_pkg::CMD_READ) |=> rsp_valid)
        else $error("Unlocked read got no answer.");

    a_hiz_blocked: assert property (
        @(posedge sys_clk) disable iff (rst)
        (ce && overvoltage_detect_disable_r) |=> !ref_hiz)
        else $error("Reference went high impedance while disabled.");

    a_wait_for_load: assert property (
        @(posedge sys_clk) disable iff (rst)
        !loaded_r |-> !cmd_ready)
        else $error("Command taken before the load finished.");

    a_write_lands: assert property (
        @(posedge sys_clk) disable iff (rst)
        (go && cmd_kind == stc_pkg::CMD_WRITE
         && cmd_addr == stc_pkg::ADDR_GAIN_FINE)
        |=> gain_fine_trim == $past(cmd_data[8:0]))
        else $error("Gain trim write was lost.");

    a_ext_ref_wins: assert property (
        @(posedge sys_clk) disable iff (rst)
        (ext_s2_r && dir_r == stc_pkg::REF_DIR_BIDIR) |-> !ref_trim_select)
        else $error("Internal reference used while pin is overdriven.");
endmodule : stc_trim_lock_cfg

// ---- stc_unlock.sv ----
module stc_unlock #(
    parameter int unsigned ACC_CYCLES = stc_pkg::ACC_TIMEOUT_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic key_ok,
    input  wire logic cmd_other,
    input  wire logic dual_key,
    output logic      unlocked,
    output logic      disabled
);
    stc_pkg::stc_ul_state_t state_r;
    logic [31:0]            timer_r;
    logic                   timeout;

    assign timeout  = (timer_r >= 32'(ACC_CYCLES - 1));
    assign unlocked = (state_r == stc_pkg::UL_OPEN);
    assign disabled = (state_r == stc_pkg::UL_DISABLED);

    // The timer only runs while the unlock sits in UL_WAIT, so a late first key
    // after the window has closed finds the link already disabled.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_r <= 32'h0000_0000;
        end else if (ce && state_r == stc_pkg::UL_WAIT && !timeout) begin
            timer_r <= timer_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= stc_pkg::UL_WAIT;
        end else if (ce) begin
            case (state_r)
                stc_pkg::UL_WAIT: begin
                    if (key_ok) begin
                        state_r <= dual_key ? stc_pkg::UL_SECOND
                                            : stc_pkg::UL_OPEN;
                    end else if (timeout) begin
                        state_r <= stc_pkg::UL_DISABLED;
                    end
                end
                stc_pkg::UL_SECOND: begin
                    if (key_ok) begin
                        state_r <= stc_pkg::UL_OPEN;
                    end else if (cmd_other) begin
                        state_r <= stc_pkg::UL_WAIT;
                    end
                end
                default: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    a_timeout_disables: assert property (
        @(posedge sys_clk) disable iff (rst)
        (ce && state_r == stc_pkg::UL_WAIT && !key_ok && timeout)
        |=> disabled)
        else $error("Access timeout did not disable the link.");

    a_dual_needs_two: assert property (
        @(posedge sys_clk) disable iff (rst)
        (ce && state_r == stc_pkg::UL_WAIT && key_ok && dual_key)
        |=> !unlocked)
        else $error("Dual-key mode opened on a single code.");

    a_single_key_opens: assert property (
        @(posedge sys_clk) disable iff (rst)
        (ce && state_r == stc_pkg::UL_WAIT && key_ok && !dual_key)
        |=> unlocked)
        else $error("Single-key mode did not open on a code.");

    a_open_stays: assert property (
        @(posedge sys_clk) disable iff (rst)
        (unlocked || disabled) |=> $stable(state_r))
        else $error("Open or disabled state changed without reset.");
endmodule : stc_unlock
